// File: hw/table_rw_pkg.sv
// Package of constants and types for the table read/write unit.
`default_nettype none
package table_rw_pkg;
   localparam int PTR_W = 21;
   localparam int DATA_W = 8;
   localparam int HOLD_N = 8;
   localparam int HOLD_SEL_W = 3;
   localparam int BYTE_SEL_BIT = 0;
   localparam logic [20:0] PTR_RESET = 21'h000000;
   localparam logic [7:0] LATCH_RESET = 8'h00;
   localparam logic [7:0] HOLD_RESET = 8'hFF;
   localparam logic [1:0] MODE_NONE = 2'h0;
   localparam logic [1:0] MODE_POST_INC = 2'h1;
   localparam logic [1:0] MODE_POST_DEC = 2'h2;
   localparam logic [1:0] MODE_PRE_INC = 2'h3;
   localparam logic [15:0] OP_READ_BASE = 16'h0008;
   localparam logic [15:0] OP_WRITE_BASE = 16'h000C;
   localparam logic [15:0] OP_MODE_MASK = 16'hFFFC;
   typedef enum logic [1:0] {
      PH_Q1,
      PH_Q2,
      PH_Q3,
      PH_Q4
   } phase_t;
endpackage
`default_nettype wire

// File: hw/ptr_step.sv
// Pointer adjust unit: steps the table pointer by the selected mode.
`default_nettype none
module ptr_step (
   input wire logic [20:0] ptr_in,
   input wire logic [1:0] mode_in,
   output logic [20:0] pre_out,
   output logic [20:0] post_out
);
   import table_rw_pkg::*;
   logic [20:0] inc;
   logic [20:0] dec;
   assign inc = ptr_in + 21'h000001;
   assign dec = ptr_in - 21'h000001;
   // The access address and the pointer left behind.
   always_comb begin
      pre_out = ptr_in;
      post_out = ptr_in;
      case (mode_in)
         MODE_POST_INC: post_out = inc;
         MODE_POST_DEC: post_out = dec;
         MODE_PRE_INC: begin
            pre_out = inc;
            post_out = inc;
         end
         default: post_out = ptr_in;
      endcase
   end
endmodule
`default_nettype wire

// File: hw/table_read_write_unit.sv
// Table read/write unit between program flash and the table latch.
// ==========================================================
`default_nettype none
module table_read_write_unit (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire table_rw_pkg::phase_t phase_in,
   input wire logic op_valid_in,
   input wire logic [15:0] opcode_in,
   input wire logic [15:0] prog_word_in,
   input wire logic ptr_load_in,
   input wire logic [20:0] ptr_data_in,
   input wire logic latch_load_in,
   input wire logic [7:0] latch_data_in,
   output logic [20:0] table_pointer_out,
   output logic [7:0] table_latch_out,
   output logic [20:0] prog_addr_out,
   output logic prog_rd_out,
   output logic busy_out,
   output logic [63:0] hold_bytes_out
);
   import table_rw_pkg::*;
   // ==========================================================
   // State
   typedef enum {
      ST_IDLE,
      ST_DECODE,
      ST_EXEC
   } state_t;
   state_t state;
   state_t next_state;
   logic is_write;
   logic next_is_write;
   logic [1:0] mode;
   logic [1:0] next_mode;
   logic [20:0] table_pointer;
   logic [20:0] next_table_pointer;
   logic [7:0] table_latch;
   logic [7:0] next_table_latch;
   logic [20:0] access_addr;
   logic [20:0] next_access_addr;
   // The byte moved in Q2 waits here until the Q4 edge.
   logic [7:0] fetched;
   logic [7:0] next_fetched;
   logic next_prog_rd;
   logic [7:0] hold [HOLD_N];
   logic [7:0] next_hold [HOLD_N];
   logic [20:0] pre_ptr;
   logic [20:0] post_ptr;
   logic op_read;
   logic op_write;
   // ==========================================================
   // Decode
   // Only the two low bits carry the mode; the rest of the word must match
   // exactly, so every other instruction passes by untouched.
   assign op_read = op_valid_in &&
      ((opcode_in & OP_MODE_MASK) == OP_READ_BASE);
   assign op_write = op_valid_in &&
      ((opcode_in & OP_MODE_MASK) == OP_WRITE_BASE);
   ptr_step u_step (
      .ptr_in(table_pointer),
      .mode_in(mode),
      .pre_out(pre_ptr),
      .post_out(post_ptr)
   );
   // ==========================================================
   // Next state
   always_comb begin
      next_state = state;
      next_is_write = is_write;
      next_mode = mode;
      next_table_pointer = table_pointer;
      next_table_latch = table_latch;
      next_access_addr = access_addr;
      next_fetched = fetched;
      next_prog_rd = 1'b0;
      case (state)
         ST_IDLE: begin
            // Loads count only while idle, so the pointer and the latch
            // never change under an access that is under way.
            if (ptr_load_in) begin
               next_table_pointer = ptr_data_in;
            end
            if (latch_load_in) begin
               next_table_latch = latch_data_in;
            end
            // Operations start at Q1 so each takes exactly two cycles.
            if ((op_read || op_write) && phase_in == PH_Q1) begin
               next_state = ST_DECODE;
               next_is_write = op_write;
               next_mode = opcode_in[1:0];
            end
         end
         ST_DECODE: begin
            // The first cycle only decodes.
            if (phase_in == PH_Q4) begin
               next_state = ST_EXEC;
               // A pre-step is taken here, one clock before the strobe rises,
               // so the address is settled when the strobe rises.
               next_access_addr = pre_ptr;
            end
         end
         ST_EXEC: begin
            case (phase_in)
               PH_Q1: begin
                  // Raised one clock early so the word stands in Q2.
                  next_prog_rd = !is_write;
               end
               PH_Q2: begin
                  if (is_write) begin
                     next_fetched = table_latch;
                  end else begin
                     // Bit 0 picks the byte in the word.
                     next_fetched = access_addr[BYTE_SEL_BIT] ?
                        prog_word_in[15:8] : prog_word_in[7:0];
                  end
               end
               PH_Q4: begin
                  // A write lands in the holding file below.
                  if (!is_write) begin
                     next_table_latch = fetched;
                  end
                  // The pointer moves last, so a post step never shifts
                  // the address that this access used.
                  next_table_pointer = post_ptr;
                  next_state = ST_IDLE;
               end
               default: next_prog_rd = 1'b0;
            endcase
         end
         default: next_state = ST_IDLE;
      endcase
   end
   // ==========================================================
   // Registers
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         state <= ST_IDLE;
         is_write <= 1'b0;
         mode <= MODE_NONE;
         table_pointer <= PTR_RESET;
         table_latch <= LATCH_RESET;
         access_addr <= PTR_RESET;
         fetched <= LATCH_RESET;
      end else begin
         state <= next_state;
         is_write <= next_is_write;
         mode <= next_mode;
         table_pointer <= next_table_pointer;
         table_latch <= next_table_latch;
         access_addr <= next_access_addr;
         fetched <= next_fetched;
      end
   end
   // ==========================================================
   // Holding file
   // A write stops in this file; nothing here touches the program array.
   logic hold_we;
   always_comb begin
      hold_we = (state == ST_EXEC) && is_write && (phase_in == PH_Q4);
      for (int i = 0; i < HOLD_N; i++) begin
         next_hold[i] = hold[i];
      end
      if (hold_we) begin
         // The three low address bits pick one of the eight bytes.
         next_hold[access_addr[HOLD_SEL_W-1:0]] = fetched;
      end
   end
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (int i = 0; i < HOLD_N; i++) begin
            hold[i] <= HOLD_RESET;
         end
      end else begin
         for (int i = 0; i < HOLD_N; i++) begin
            hold[i] <= next_hold[i];
         end
      end
   end
   // ==========================================================
   // Outputs
   // Each port is a flop of its own, loaded from the same next value as
   // its working register, so the pins show no combinational path.
   logic next_busy;
   logic [63:0] next_hold_bytes;
   always_comb begin
      next_busy = (next_state != ST_IDLE);
      next_hold_bytes = 64'h0000000000000000;
      for (int i = 0; i < HOLD_N; i++) begin
         next_hold_bytes[i*8 +: 8] = next_hold[i];
      end
   end
   always_ff @(posedge sys_clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         table_pointer_out <= PTR_RESET;
         table_latch_out <= LATCH_RESET;
         prog_addr_out <= PTR_RESET;
         prog_rd_out <= 1'b0;
         busy_out <= 1'b0;
         hold_bytes_out <= {HOLD_N{HOLD_RESET}};
      end else begin
         table_pointer_out <= next_table_pointer;
         table_latch_out <= next_table_latch;
         prog_addr_out <= next_access_addr;
         prog_rd_out <= next_prog_rd;
         busy_out <= next_busy;
         hold_bytes_out <= next_hold_bytes;
      end
   end
endmodule
`default_nettype wire

// File: test/table_rw_props.sv
// Checker bound to the table unit.
`default_nettype none
module table_rw_props (
   input wire logic sys_clk_in,
   input wire logic nrst_in,
   input wire table_rw_pkg::phase_t phase_in,
   input wire logic [15:0] opcode_in,
   input wire logic [15:0] prog_word_in,
   input wire logic [20:0] table_pointer_out,
   input wire logic [7:0] table_latch_out,
   input wire logic [20:0] prog_addr_out,
   input wire logic prog_rd_out,
   input wire logic busy_out,
   input wire logic [63:0] hold_bytes_out
);
   timeunit 1ns;
   timeprecision 1ns;
   import table_rw_pkg::*;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (!nrst_in);
   sequence s_busy;
      busy_out[*7] ##1 !busy_out;
   endsequence
   function automatic logic [20:0] st(input logic [1:0] m);
      return {{20{m == MODE_POST_DEC}}, m != MODE_NONE};
   endfunction
   a_busy_len: assert property ($rose(busy_out) |-> s_busy)
      else $error("busy");
   a_rd_phase: assert property (prog_rd_out |->
      phase_in == PH_Q2 && busy_out ##1 !prog_rd_out) else $error("strobe");
   a_rd_addr: assert property (prog_rd_out |->
      prog_addr_out == table_pointer_out +
      21'($past(opcode_in[1:0], 5) == MODE_PRE_INC)) else $error("addr");
   a_rd_byte: assert property (prog_rd_out |-> ##3
      table_latch_out ==
      8'($past(prog_word_in >> {prog_addr_out[0], 3'h0}, 3)))
      else $error("byte");
   a_latch_q4: assert property ($changed(table_latch_out) &&
      $past(busy_out) |-> $past(phase_in) == PH_Q4) else $error("latch");
   a_hold_q4: assert property ($changed(hold_bytes_out) |->
      $past(phase_in) == PH_Q4 && $past(opcode_in[2], 8)) else $error("hold");
   a_ptr_step: assert property ($fell(busy_out) |->
      table_pointer_out == $past(table_pointer_out) +
      st($past(opcode_in[1:0], 8))) else $error("pointer");
   a_wr_keep: assert property ($fell(busy_out) &&
      $past(opcode_in[2], 8) |-> $stable(table_latch_out)) else $error("keep");
endmodule
bind table_read_write_unit table_rw_props u_props (
   .sys_clk_in(sys_clk_in),
   .nrst_in(nrst_in),
   .phase_in(phase_in),
   .opcode_in(opcode_in),
   .prog_word_in(prog_word_in),
   .table_pointer_out(table_pointer_out),
   .table_latch_out(table_latch_out),
   .prog_addr_out(prog_addr_out),
   .prog_rd_out(prog_rd_out),
   .busy_out(busy_out),
   .hold_bytes_out(hold_bytes_out)
);
`default_nettype wire

// File: test/prog_flash_model.sv
// Program flash model that answers byte fetches.
`default_nettype none
module prog_flash_model (
   input wire logic [20:0] addr_in,
   input wire logic rd_in,
   output logic [15:0] word_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] w;
   assign w = {addr_in[8:1] ^ 8'h5A, addr_in[8:1]};
   // Off a fetch the bus shows the inverse, so a late sample cannot pass.
   assign word_out = rd_in ? w : ~w;
endmodule
`default_nettype wire

// File: test/tb_table_read_write_unit.sv
// Bench for the table read/write unit.
`default_nettype none
module tb_table_read_write_unit;
   timeunit 1ns;
   timeprecision 1ns;
   import table_rw_pkg::*;
   logic sys_clk_in = 1'h0;
   logic nrst_in = 1'h0;
   logic op_valid_in = 1'h0;
   logic ld = 1'h0;
   phase_t phase_in = PH_Q1;
   logic [15:0] opcode_in = 16'h0;
   wire logic [15:0] prog_word_in;
   logic [20:0] ptr_data_in = 21'h0;
   logic [7:0] latch_data_in = 8'h0;
   logic [20:0] table_pointer_out, prog_addr_out;
   logic [7:0] table_latch_out;
   logic prog_rd_out;
   logic busy_out;
   logic [63:0] hold_bytes_out;
   int err_total = 0;
   int tests_run = 0;
   always #20 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      phase_in <= nrst_in ? phase_t'(phase_in + 2'h1) : PH_Q1;
   end
   table_read_write_unit u_dut (
      .sys_clk_in(sys_clk_in),
      .nrst_in(nrst_in),
      .phase_in(phase_in),
      .op_valid_in(op_valid_in),
      .opcode_in(opcode_in),
      .prog_word_in(prog_word_in),
      .ptr_load_in(ld),
      .ptr_data_in(ptr_data_in),
      .latch_load_in(ld),
      .latch_data_in(latch_data_in),
      .table_pointer_out(table_pointer_out),
      .table_latch_out(table_latch_out),
      .prog_addr_out(prog_addr_out),
      .prog_rd_out(prog_rd_out),
      .busy_out(busy_out),
      .hold_bytes_out(hold_bytes_out)
   );
   prog_flash_model u_mem (.addr_in(prog_addr_out), .rd_in(prog_rd_out),
      .word_out(prog_word_in));
   task chk(input string n, input logic [63:0] s, e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("wrong value %s exp %h got %h", n, e, s);
      end
   endtask
   task end_sim;
      $display("%0d checks, %0d wrong", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   // Loads pointer and latch while idle, then issues the op at a Q1.
   task op(input logic [20:0] p, input logic [7:0] d, input logic [15:0] c);
      @(posedge sys_clk_in);
      ld <= 1'h1;
      ptr_data_in <= p;
      latch_data_in <= d;
      @(posedge sys_clk_in);
      ld <= 1'h0;
      do @(negedge sys_clk_in); while (phase_in !== PH_Q4);
      @(posedge sys_clk_in);
      op_valid_in <= 1'h1;
      opcode_in <= c;
      @(posedge sys_clk_in);
      op_valid_in <= 1'h0;
      @(negedge sys_clk_in);
      chk("busy", busy_out, 64'h1);
      repeat (6) @(negedge sys_clk_in);
      chk("busy end", busy_out, 64'h1);
      @(negedge sys_clk_in);
      chk("idle", busy_out, 64'h0);
   endtask
   task t_reset;
      @(negedge sys_clk_in);
      chk("reset hold", hold_bytes_out, {8{HOLD_RESET}});
      chk("reset busy", busy_out, 64'h0);
      $display("reset done");
   endtask
   task t_read;
      logic [20:0] p;
      logic [20:0] q;
      logic [7:0] b;
      for (int m = 0; m < 4; m++) begin
         p = 21'h1FFFFF + 21'(m == 3);
         q = (m == 2) ? p - 21'h1 : p + 21'(m == 1);
         b = p[0] ? p[8:1] ^ 8'h5A : p[8:1];
         op(21'h1FFFFF, 8'hC3, OP_READ_BASE | 16'(m));
         chk("latch", table_latch_out, b);
         chk("ptr", table_pointer_out, q);
      end
      $display("read done");
   endtask
   task t_write;
      logic [20:0] p;
      logic [20:0] q;
      logic [7:0] b;
      for (int m = 0; m < 4; m++) begin
         p = 21'h7 + 21'(m == 3);
         op(21'h7, 8'hA0 + 8'(m), OP_WRITE_BASE | 16'(m));
         b = 8'hA0 + 8'(m);
         chk("hold", hold_bytes_out[8*p[2:0] +: 8], b);
         q = (m == 2) ? 21'h6 : 21'h7 + 21'(m[0]);
         chk("wptr", table_pointer_out, q);
      end
      chk("all", hold_bytes_out, {8'hA2, {6{HOLD_RESET}}, 8'hA3});
      $display("write done");
   endtask
   initial begin
      repeat (6) @(posedge sys_clk_in);
      nrst_in <= 1'h1;
      t_reset;
      t_read;
      t_write;
      end_sim;
   end
   initial begin
      #80000;
      err_total++;
      end_sim;
   end
endmodule
`default_nettype wire
